// *** group_select_pkg.sv ***
package group_select_pkg;

    localparam int GROUP_COUNT = 8;
    localparam int ADDR_W = 8;

    // Register byte offsets.
    localparam logic [7:0] OFFS_USED = 8'h00;
    localparam logic [7:0] OFFS_FORCE_EN = 8'h04;
    localparam logic [7:0] OFFS_FORCE_GRP = 8'h08;
    localparam logic [7:0] OFFS_REMOTE = 8'h0C;
    localparam logic [7:0] OFFS_ACTIVE = 8'h10;
    localparam logic [7:0] OFFS_EVENTS = 8'h14;
    localparam logic [7:0] OFFS_REQUEST = 8'h18;

    // Field positions and values after reset.
    localparam int ACTIVE_MODE_LSB = 8;
    localparam int EV_ENABLED = 0;
    localparam int EV_DISABLED = 1;
    localparam int EV_STATUS = 2;
    localparam int EV_FAIL = 3;
    localparam logic [2:0] USED_RESET = 3'h0;
    localparam logic [3:0] GROUP_NONE = 4'h0;
    localparam logic [3:0] GROUP_MAX = 4'h8;
    localparam logic [7:0] GROUP_ONE_HOT = 8'h01;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_IDLE = 2'h0,
        MODE_AUTO = 2'h1,
        MODE_FORCED = 2'h3
    } mode_t;

    typedef enum logic [2:0] {
        SEL_USED, SEL_FORCE_EN, SEL_FORCE_GRP, SEL_REMOTE,
        SEL_ACTIVE, SEL_EVENTS, SEL_REQUEST, SEL_NONE
    } reg_sel_t;

    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axi_resp_t;

    typedef struct packed {
        axi_resp_t bus;
        logic awHeld;
        logic wHeld;
        logic [ADDR_W-1:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic [2:0] used;
        logic forceEnable;
        logic [3:0] forceGroup;
        logic [3:0] remoteGroup;
        logic [7:0] active;
        mode_t mode;
        logic [3:0] events;
    } state_t;

endpackage

// *** setting_group_selector.sv ***
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
module setting_group_selector (
    input wire logic clk,
    input wire logic rst,
    input wire group_select_pkg::axi_req_t axiIn,
    output group_select_pkg::axi_resp_t axiOut,
    input wire logic [7:0] groupRequest,
    output logic [7:0] activeGroup
);

    group_select_pkg::state_t st;
    group_select_pkg::state_t next_st;
    logic [7:0] enMask;
    logic [7:0] reqMasked;
    logic [7:0] remoteReq;
    logic [7:0] autoReq;
    logic [7:0] lowest;
    logic [7:0] forceHot;
    logic [7:0] remoteHot;
    logic doWrite;
    logic forceWr;
    logic remoteWr;
    logic forceOk;
    logic activeOk;
    group_select_pkg::reg_sel_t wSel;
    group_select_pkg::reg_sel_t rSel;

    function automatic group_select_pkg::reg_sel_t decodeReg(
        input logic [7:0] addr
    );
        logic [7:0] a;
        a = {addr[7:2], 2'h0};
        if (a == group_select_pkg::OFFS_USED) begin
            return group_select_pkg::SEL_USED;
        end else if (a == group_select_pkg::OFFS_FORCE_EN) begin
            return group_select_pkg::SEL_FORCE_EN;
        end else if (a == group_select_pkg::OFFS_FORCE_GRP) begin
            return group_select_pkg::SEL_FORCE_GRP;
        end else if (a == group_select_pkg::OFFS_REMOTE) begin
            return group_select_pkg::SEL_REMOTE;
        end else if (a == group_select_pkg::OFFS_ACTIVE) begin
            return group_select_pkg::SEL_ACTIVE;
        end else if (a == group_select_pkg::OFFS_EVENTS) begin
            return group_select_pkg::SEL_EVENTS;
        end else if (a == group_select_pkg::OFFS_REQUEST) begin
            return group_select_pkg::SEL_REQUEST;
        end else begin
            return group_select_pkg::SEL_NONE;
        end
    endfunction

    // Codes above eight decode to no group, so they can never be applied.
    function automatic logic [7:0] groupToOneHot(input logic [3:0] code);
        logic [7:0] hot;
        hot = 8'h00;
        if (code != group_select_pkg::GROUP_NONE &&
            code <= group_select_pkg::GROUP_MAX) begin
            hot[3'(code - 4'h1)] = 1'b1;
        end
        return hot;
    endfunction

    function automatic logic [3:0] oneHotToGroup(input logic [7:0] hot);
        logic [3:0] code;
        code = group_select_pkg::GROUP_NONE;
        for (int i = group_select_pkg::GROUP_COUNT - 1; i >= 0; i--) begin
            if (hot[i]) begin
                code = 4'(i + 1);
            end
        end
        return code;
    endfunction

    function automatic logic [3:0] clipGroup(input logic [3:0] code);
        return (code > group_select_pkg::GROUP_MAX) ?
            group_select_pkg::GROUP_NONE : code;
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < group_select_pkg::GROUP_COUNT; gi++) begin : g_en
            assign enMask[gi] = (3'(gi) <= st.used);
        end
    endgenerate

    assign doWrite = st.awHeld && st.wHeld && !st.bus.bvalid;
    assign wSel = decodeReg(st.awAddr);
    assign rSel = decodeReg(axiIn.araddr);
    assign forceWr = doWrite && st.wStrb[0] &&
        wSel == group_select_pkg::SEL_FORCE_GRP;
    assign remoteWr = doWrite && st.wStrb[0] &&
        wSel == group_select_pkg::SEL_REMOTE;
    assign forceHot = groupToOneHot(st.wData[3:0]);
    assign remoteHot = groupToOneHot(st.wData[3:0]);
    assign forceOk = forceWr && st.forceEnable &&
        (forceHot & enMask) != 8'h00;
    assign activeOk = (st.active & enMask) != 8'h00;
    assign reqMasked = groupRequest & enMask;
    // A remote change is merged as a pulse request, so held levels of
    // higher-priority groups win over it by plain priority.
    assign remoteReq = (remoteWr && st.mode == group_select_pkg::MODE_AUTO) ?
        (remoteHot & enMask) : 8'h00;
    assign autoReq = reqMasked | remoteReq;
    assign lowest = autoReq & (~autoReq + 8'h01);

    always_comb begin
        next_st = st;
        // Write address and write data are taken independently.
        if (axiIn.awvalid && st.bus.awready) begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = axiIn.awaddr;
        end
        if (axiIn.wvalid && st.bus.wready) begin
            next_st.wHeld = 1'b1;
            next_st.wData = axiIn.wdata;
            next_st.wStrb = axiIn.wstrb;
        end
        if (st.bus.bvalid && axiIn.bready) begin
            next_st.bus.bvalid = 1'b0;
        end
        if (doWrite) begin
            next_st.awHeld = 1'b0;
            next_st.wHeld = 1'b0;
            next_st.bus.bvalid = 1'b1;
            next_st.bus.bresp = (wSel == group_select_pkg::SEL_NONE) ?
                group_select_pkg::RESP_SLVERR : group_select_pkg::RESP_OKAY;
            if (st.wStrb[0]) begin
                case (wSel)
                    group_select_pkg::SEL_USED: begin
                        next_st.used = st.wData[2:0];
                    end
                    group_select_pkg::SEL_FORCE_EN: begin
                        next_st.forceEnable = st.wData[0];
                    end
                    group_select_pkg::SEL_FORCE_GRP: begin
                        next_st.forceGroup = clipGroup(st.wData[3:0]);
                    end
                    group_select_pkg::SEL_REMOTE: begin
                        next_st.remoteGroup = clipGroup(st.wData[3:0]);
                    end
                    group_select_pkg::SEL_EVENTS: begin
                        next_st.events = st.events & ~st.wData[3:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
        next_st.bus.awready = !next_st.awHeld && !next_st.bus.bvalid;
        next_st.bus.wready = !next_st.wHeld && !next_st.bus.bvalid;

        // Read channel: one read is answered before the next is taken.
        if (st.bus.rvalid && axiIn.rready) begin
            next_st.bus.rvalid = 1'b0;
        end
        if (axiIn.arvalid && st.bus.arready) begin
            next_st.bus.rvalid = 1'b1;
            next_st.bus.rresp = group_select_pkg::RESP_OKAY;
            next_st.bus.rdata = 32'h00000000;
            case (rSel)
                group_select_pkg::SEL_USED: begin
                    next_st.bus.rdata[2:0] = st.used;
                end
                group_select_pkg::SEL_FORCE_EN: begin
                    next_st.bus.rdata[0] = st.forceEnable;
                end
                group_select_pkg::SEL_FORCE_GRP: begin
                    next_st.bus.rdata[3:0] = st.forceGroup;
                end
                group_select_pkg::SEL_REMOTE: begin
                    next_st.bus.rdata[3:0] = st.remoteGroup;
                end
                group_select_pkg::SEL_ACTIVE: begin
                    next_st.bus.rdata[3:0] = oneHotToGroup(st.active);
                    next_st.bus.rdata[group_select_pkg::ACTIVE_MODE_LSB +: 2] =
                        st.mode;
                end
                group_select_pkg::SEL_EVENTS: begin
                    next_st.bus.rdata[3:0] = st.events;
                end
                group_select_pkg::SEL_REQUEST: begin
                    next_st.bus.rdata[7:0] = groupRequest;
                end
                default: begin
                    next_st.bus.rresp = group_select_pkg::RESP_SLVERR;
                end
            endcase
        end
        next_st.bus.arready = !next_st.bus.rvalid;

        // Group selection. A group left outside the enabled range by a
        // shrinking used-groups value falls back to group one, unless an enabled request (auto) or a valid forced write selects another.
        case (st.mode)
            group_select_pkg::MODE_AUTO: begin
                if (autoReq != 8'h00) begin
                    next_st.active = lowest;
                end else if (!activeOk) begin
                    next_st.active = group_select_pkg::GROUP_ONE_HOT;
                end
            end
            group_select_pkg::MODE_FORCED: begin
                if (forceOk) begin
                    next_st.active = forceHot;
                end else if (!activeOk) begin
                    next_st.active = group_select_pkg::GROUP_ONE_HOT;
                end
            end
            default: begin
                next_st.active = group_select_pkg::GROUP_ONE_HOT;
            end
        endcase

        next_st.mode = next_st.forceEnable ? group_select_pkg::MODE_FORCED :
            (next_st.used == group_select_pkg::USED_RESET) ?
            group_select_pkg::MODE_IDLE : group_select_pkg::MODE_AUTO;

        // Events are sticky; a new event wins over a clear in the same cycle.
        if (next_st.used > st.used) begin
            next_st.events[group_select_pkg::EV_ENABLED] = 1'b1;
        end
        if (next_st.used < st.used) begin
            next_st.events[group_select_pkg::EV_DISABLED] = 1'b1;
        end
        if (next_st.active != st.active ||
            next_st.forceEnable != st.forceEnable) begin
            next_st.events[group_select_pkg::EV_STATUS] = 1'b1;
        end
        if ((forceWr && st.wData[3:0] != group_select_pkg::GROUP_NONE &&
             !forceOk) ||
            (remoteWr && st.wData[3:0] != group_select_pkg::GROUP_NONE &&
             (remoteReq == 8'h00 || lowest != remoteHot))) begin
            next_st.events[group_select_pkg::EV_FAIL] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.active <= group_select_pkg::GROUP_ONE_HOT;
        end else begin
            st <= next_st;
        end
    end

    assign axiOut = st.bus;
    assign activeGroup = st.active;

    property p_oneHot;
        @(posedge clk) disable iff (rst)
        $onehot(st.active);
    endproperty
    a_oneHot: assert property (p_oneHot)
        else $error("active group is not exactly one");

    property p_idle;
        @(posedge clk) disable iff (rst)
        st.used == group_select_pkg::USED_RESET |=>
            st.active == group_select_pkg::GROUP_ONE_HOT;
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle selector left group one");

    property p_forceIgnores;
        @(posedge clk) disable iff (rst)
        st.mode == group_select_pkg::MODE_FORCED && !doWrite && activeOk &&
            groupRequest != 8'h00 |=> $stable(st.active);
    endproperty
    a_forceIgnores: assert property (p_forceIgnores)
        else $error("request changed group while forcing");

    property p_priority;
        @(posedge clk) disable iff (rst)
        st.mode == group_select_pkg::MODE_AUTO && autoReq != 8'h00 |=>
            st.active == $past(lowest);
    endproperty
    a_priority: assert property (p_priority)
        else $error("wrong group won priority");

    property p_staticOne;
        @(posedge clk) disable iff (rst)
        st.mode == group_select_pkg::MODE_AUTO && groupRequest[0] [*2] |->
            st.active == group_select_pkg::GROUP_ONE_HOT;
    endproperty
    a_staticOne: assert property (p_staticOne)
        else $error("held group one request did not block others");

    property p_hold;
        @(posedge clk) disable iff (rst)
        st.mode == group_select_pkg::MODE_AUTO && autoReq == 8'h00 &&
            activeOk |=> $stable(st.active);
    endproperty
    a_hold: assert property (p_hold)
        else $error("group changed without a request");

    property p_forceApply;
        @(posedge clk) disable iff (rst)
        forceOk |=> st.active == $past(forceHot) &&
            (st.events[group_select_pkg::EV_STATUS] || $stable(st.active));
    endproperty
    a_forceApply: assert property (p_forceApply)
        else $error("valid forced change not applied");

    property p_failEvent;
        @(posedge clk) disable iff (rst)
        forceWr && st.wData[3:0] != group_select_pkg::GROUP_NONE && !forceOk
            |=> st.events[group_select_pkg::EV_FAIL] &&
            ($stable(st.active) || !$past(st.forceEnable));
    endproperty
    a_failEvent: assert property (p_failEvent)
        else $error("refused forced change not flagged");

    property p_forceKeep;
        @(posedge clk) disable iff (rst)
        st.forceEnable && !(doWrite &&
            wSel == group_select_pkg::SEL_FORCE_EN) |=> st.forceEnable;
    endproperty
    a_forceKeep: assert property (p_forceKeep)
        else $error("forcing enable dropped by itself");

    property p_reset;
        @(posedge clk)
        rst |=> st.active == group_select_pkg::GROUP_ONE_HOT &&
            !st.forceEnable && st.forceGroup == group_select_pkg::GROUP_NONE &&
            st.remoteGroup == group_select_pkg::GROUP_NONE;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset state wrong");

endmodule

// *** group_request_source.sv ***
// Stands in for the relay logic and digital inputs that raise group requests.
// Commands are registered, so a one-cycle pulse command becomes a one-cycle
// request and a level command stays up for as long as it is held.
module group_request_source (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] levelCmd,
    input wire logic [7:0] pulseCmd,
    output logic [7:0] groupRequest
);
    timeunit 1ns;
    timeprecision 100ps;

    always_ff @(posedge clk) begin
        if (rst) begin
            groupRequest <= 8'h00;
        end else begin
            groupRequest <= levelCmd | pulseCmd;
        end
    end
endmodule

// *** setting_group_selector_tb_top.sv ***
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    miscompares++; \
    $display("wrong value %s expected %h seen %h", nm, (e), (g)); end end

module setting_group_selector_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk;
    logic rst;
    group_select_pkg::axi_req_t axiIn;
    group_select_pkg::axi_resp_t axiOut;
    logic [7:0] groupRequest;
    logic [7:0] activeGroup;
    logic [7:0] levelCmd;
    logic [7:0] pulseCmd;
    logic [31:0] rdVal;
    logic [1:0] resp;
    int miscompares = 0;
    int cmp_count = 0;
    int i;

    setting_group_selector dut (
        .clk(clk),
        .rst(rst),
        .axiIn(axiIn),
        .axiOut(axiOut),
        .groupRequest(groupRequest),
        .activeGroup(activeGroup)
    );

    group_request_source source (
        .clk(clk),
        .rst(rst),
        .levelCmd(levelCmd),
        .pulseCmd(pulseCmd),
        .groupRequest(groupRequest)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic timed_out;
        miscompares++;
        $display("bus answer did not arrive in time");
        wrap_up();
    endtask

    // Handshakes are sampled at the falling edge, where every register of the
    // slave has settled, and acted on by the master at the next rising edge.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        logic awT, wT, bT, done;
        done = 1'b0;
        r = 2'h3;
        @(posedge clk);
        axiIn.awaddr <= a;
        axiIn.awvalid <= 1'b1;
        axiIn.wdata <= d;
        axiIn.wstrb <= 4'hF;
        axiIn.wvalid <= 1'b1;
        axiIn.bready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(negedge clk);
            awT = axiIn.awvalid & axiOut.awready;
            wT = axiIn.wvalid & axiOut.wready;
            bT = axiIn.bready & axiOut.bvalid;
            if (bT) r = axiOut.bresp;
            @(posedge clk);
            if (awT) axiIn.awvalid <= 1'b0;
            if (wT) axiIn.wvalid <= 1'b0;
            if (bT) begin
                axiIn.bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) timed_out();
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        logic arT, rT, done;
        done = 1'b0;
        r = 2'h3;
        d = 32'h0;
        @(posedge clk);
        axiIn.araddr <= a;
        axiIn.arvalid <= 1'b1;
        axiIn.rready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(negedge clk);
            arT = axiIn.arvalid & axiOut.arready;
            rT = axiIn.rready & axiOut.rvalid;
            if (rT) r = axiOut.rresp;
            if (rT) d = axiOut.rdata;
            @(posedge clk);
            if (arT) axiIn.arvalid <= 1'b0;
            if (rT) begin
                axiIn.rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) timed_out();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi_write(a, d, resp);
        `CHK("bresp", group_select_pkg::RESP_OKAY, resp)
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        axi_read(a, rdVal, resp);
        `CHK("rresp", group_select_pkg::RESP_OKAY, resp)
        `CHK("rdata", e, rdVal)
    endtask

    // Three edges cover the request register in the source and the one-edge
    // answer of the selector, with one spare.
    task automatic act_chk(input logic [7:0] e);
        repeat (3) @(posedge clk);
        @(negedge clk);
        `CHK("activeGroup", e, activeGroup)
    endtask

    task automatic pulse(input logic [7:0] g);
        @(posedge clk);
        pulseCmd <= g;
        @(posedge clk);
        pulseCmd <= 8'h00;
    endtask

    task automatic level(input logic [7:0] g);
        @(posedge clk);
        levelCmd <= g;
    endtask

    task automatic end_test(input string nm);
        $display("test %s finished, mismatches so far %0d", nm, miscompares);
    endtask

    initial begin
        rst = 1'b1;
        axiIn = '0;
        levelCmd = 8'h00;
        pulseCmd = 8'h00;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        act_chk(8'h01);
        rd_chk(group_select_pkg::OFFS_USED, 32'h0);
        rd_chk(group_select_pkg::OFFS_FORCE_EN, 32'h0);
        rd_chk(group_select_pkg::OFFS_FORCE_GRP, 32'h0);
        rd_chk(group_select_pkg::OFFS_REMOTE, 32'h0);
        rd_chk(group_select_pkg::OFFS_ACTIVE, 32'h1);
        rd_chk(group_select_pkg::OFFS_EVENTS, 32'h0);
        end_test("reset");
        pulse(8'h04);
        act_chk(8'h01);
        level(8'h02);
        act_chk(8'h01);
        level(8'h00);
        end_test("idle");
        wr(group_select_pkg::OFFS_USED, 32'h7);
        rd_chk(group_select_pkg::OFFS_USED, 32'h7);
        rd_chk(group_select_pkg::OFFS_EVENTS, 32'h1);
        wr(group_select_pkg::OFFS_EVENTS, 32'hF);
        rd_chk(group_select_pkg::OFFS_EVENTS, 32'h0);
        pulse(8'h10);
        act_chk(8'h10);
        act_chk(8'h10);
        rd_chk(group_select_pkg::OFFS_ACTIVE, 32'h105);
        pulse(8'h60);
        act_chk(8'h20);
        end_test("pulse");
        // A level on each of groups one to seven in turn, with a standing level on group eight, pairs with a pulse on group seven.
        for (i = 0; i < 7; i++) begin
            level(8'h80 | (8'h01 << i));
            act_chk(8'h01 << i);
            pulse(8'h40);
            act_chk(8'h01 << i);
        end
        rd_chk(group_select_pkg::OFFS_REQUEST, 32'hC0);
        end_test("priority");
        level(8'h02);
        act_chk(8'h02);
        wr(group_select_pkg::OFFS_EVENTS, 32'hF);
        wr(group_select_pkg::OFFS_REMOTE, 32'h5);
        act_chk(8'h02);
        rd_chk(group_select_pkg::OFFS_EVENTS, 32'h8);
        rd_chk(group_select_pkg::OFFS_REMOTE, 32'h5);
        level(8'h00);
        act_chk(8'h02);
        wr(group_select_pkg::OFFS_REMOTE, 32'h6);
        act_chk(8'h20);
        end_test("remote");
        wr(group_select_pkg::OFFS_FORCE_EN, 32'h1);
        level(8'h01);
        act_chk(8'h20);
        rd_chk(group_select_pkg::OFFS_FORCE_EN, 32'h1);
        wr(group_select_pkg::OFFS_FORCE_GRP, 32'h3);
        act_chk(8'h04);
        rd_chk(group_select_pkg::OFFS_ACTIVE, 32'h303);
        wr(group_select_pkg::OFFS_USED, 32'h2);
        rd_chk(group_select_pkg::OFFS_EVENTS, 32'hE);
        wr(group_select_pkg::OFFS_EVENTS, 32'hF);
        wr(group_select_pkg::OFFS_FORCE_GRP, 32'h5);
        act_chk(8'h04);
        rd_chk(group_select_pkg::OFFS_EVENTS, 32'h8);
        wr(group_select_pkg::OFFS_FORCE_GRP, 32'h9);
        rd_chk(group_select_pkg::OFFS_FORCE_GRP, 32'h0);
        wr(group_select_pkg::OFFS_FORCE_EN, 32'h0);
        act_chk(8'h01);
        level(8'h00);
        wr(group_select_pkg::OFFS_FORCE_EN, 32'h1);
        wr(group_select_pkg::OFFS_FORCE_GRP, 32'h2);
        act_chk(8'h02);
        wr(group_select_pkg::OFFS_FORCE_EN, 32'h0);
        act_chk(8'h02);
        end_test("forcing");
        axi_write(8'h1C, 32'h1, resp);
        `CHK("bresp", group_select_pkg::RESP_SLVERR, resp)
        axi_read(8'h1C, rdVal, resp);
        `CHK("rresp", group_select_pkg::RESP_SLVERR, resp)
        `CHK("rdata", 32'h0, rdVal)
        act_chk(8'h02);
        end_test("unmapped");
        wrap_up();
    end
endmodule
